// ===== src/fpu_err_map.svh
// offsets, field positions, reset values for the fp error reporting block
`ifndef FPU_ERR_MAP_SVH
`define FPU_ERR_MAP_SVH
`define FE_ADDR_W 8
`define FE_CTRL_OFS 8'h00
`define FE_STATUS_OFS 8'h04
`define FE_CMD_OFS 8'h08
`define FE_RESTORE_OFS 8'h0c
`define FE_IPTR_OFS 8'h10
`define FE_OPTR_OFS 8'h14
`define FE_EVT_OFS 8'h18
`define FE_EVT_CLR_OFS 8'h1c
`define FE_EVT_EN_OFS 8'h20
`define FE_NFLAGS 6
`define FE_NEVT 3
`define FE_MASK_RST 6'h3f
`define FE_NATIVE_BIT 8
`define FE_NATIVE_RST 1'b0
`define FE_ST_PEND_BIT 7
`define FE_ST_STATE_LSB 8
`define FE_CMD_CLR_BIT 0
`define FE_CMD_INIT_BIT 1
`define FE_EVT_UNMASKED 0
`define FE_EVT_FROZEN 1
`define FE_EVT_HANDLER 2
`endif

// ===== src/fpu_err_pkg.sv
// types shared by the fp error reporting block
package fpu_err_pkg;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_FROZEN = 2'b01,
        ST_HANDLER = 2'b10
    } state_t;
    typedef struct packed {
        logic valid;
        logic is_fp;
        logic is_wait;
        logic no_wait;
        logic [31:0] ip;
        logic [31:0] op;
    } instr_t;
    typedef struct packed {
        logic valid;
        logic at_detect;
        logic [5:0] flags;
    } exc_t;
endpackage

// ===== src/fpu_exc_flags.sv
// sticky exception flags of the status word
`timescale 1ns/100ps
module fpu_exc_flags #(
    parameter int N = 6
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // flag sources
    input wire logic [N-1:0] set_flags,
    input wire logic clr,
    input wire logic restore,
    input wire logic [N-1:0] restore_flags,
    // state
    output logic [N-1:0] flags_reg
);
    logic [N-1:0] flags_next;

    // ==========================================
    // sticky flags, a new set wins over a clear
    always_comb begin
        flags_next = flags_reg;
        if (clr) begin
            flags_next = '0;
        end else if (restore) begin
            flags_next = restore_flags;
        end
        flags_next = flags_next | set_flags;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flags_reg <= '0;
        end else if (ce) begin
            flags_reg <= flags_next;
        end
    end

    chk_flags_sticky: assert property (@(posedge ref_clk) disable iff (rst)
        ce && !clr && !restore |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
        else $error("exception flag lost without a clear");
endmodule

// ===== src/fpu_evt_irq.sv
// sticky event status, enable, write-one clear and level interrupt
`timescale 1ns/100ps
module fpu_evt_irq #(
    parameter int N = 3
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // events and software access
    input wire logic [N-1:0] evt,
    input wire logic clr_we,
    input wire logic en_we,
    input wire logic [N-1:0] wdata,
    // state and interrupt
    output logic [N-1:0] status_reg,
    output logic [N-1:0] enable_reg,
    output logic irq
);
    logic [N-1:0] status_next;
    logic [N-1:0] enable_next;

    // ==========================================
    // set wins over clear
    always_comb begin
        status_next = status_reg;
        if (clr_we) begin
            status_next = status_reg & ~wdata;
        end
        status_next = status_next | evt;
        enable_next = en_we ? wdata : enable_reg;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_reg <= '0;
            enable_reg <= '0;
        end else if (ce) begin
            status_reg <= status_next;
            enable_reg <= enable_next;
        end
    end

    assign irq = |(status_reg & enable_reg);
endmodule

// ===== src/fpu_err_report.sv
// fp error reporting: error output, freeze, handler entry, apb registers
`timescale 1ns/100ps
`include "fpu_err_map.svh"
// Behaviour
// - unmasked error in compat mode reaches interrupt
// - error output at detect or next fp
// - freeze before waiting fp unless no-wait, or ignored with native off
// - frozen until external interrupt arrives
// - error irq disabled: wait any interrupt
// - native off and ignore active: continue
// - error line doubles as coprocessor status (not done: fp_error_out_n only reports errors, high after reset)
// - uncleared flags re-raise error on fp
// - pointers updated at each numeric start
// - unmasked exception halts, enters handler
// - mask bit one: no error output
// - flags sticky until clear/init/restore
module fpu_err_report (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core side
    input wire fpu_err_pkg::instr_t instr,
    output logic instr_ready,
    input wire fpu_err_pkg::exc_t exc,
    output logic exc_abort,
    output logic handler_entry,
    input wire logic interrupt_return,
    // pins
    input wire logic ignore_numeric_error_in_n,
    input wire logic maskable_irq_in,
    output logic fp_error_out_n,
    output logic irq
);
    localparam int NF = `FE_NFLAGS;
    localparam int NEVT = `FE_NEVT;

    fpu_err_pkg::state_t state_reg;
    fpu_err_pkg::state_t state_next;
    logic [NF-1:0] mask_reg;
    logic [NF-1:0] mask_next;
    logic native_reg;
    logic native_next;
    logic err_out_reg;
    logic err_out_next;
    logic abort_reg;
    logic abort_next;
    logic entry_reg;
    logic entry_next;
    logic [31:0] ip_reg;
    logic [31:0] ip_next;
    logic [31:0] op_reg;
    logic [31:0] op_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic slverr_reg;
    logic slverr_next;
    logic [NF-1:0] flags;
    logic [NEVT-1:0] evt_status;
    logic [NEVT-1:0] evt_enable;
    logic [NEVT-1:0] evt;
    logic wr_acc;
    logic cmd_we;
    logic flag_clr;
    logic flag_init;
    logic restore_we;
    logic pending;
    logic new_unmasked;
    logic waits;
    logic honor;
    logic stall_req;
    logic accept_fp;

    // ==========================================
    // address decode
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == `FE_CTRL_OFS) || (a == `FE_STATUS_OFS) ||
                   (a == `FE_CMD_OFS) || (a == `FE_RESTORE_OFS) ||
                   (a == `FE_IPTR_OFS) || (a == `FE_OPTR_OFS) ||
                   (a == `FE_EVT_OFS) || (a == `FE_EVT_CLR_OFS) ||
                   (a == `FE_EVT_EN_OFS);
    endfunction

    assign wr_acc = psel && penable && pwrite && addr_hit(paddr);
    assign cmd_we = wr_acc && (paddr == `FE_CMD_OFS);
    assign flag_clr = cmd_we && pwdata[`FE_CMD_CLR_BIT];
    assign flag_init = cmd_we && pwdata[`FE_CMD_INIT_BIT];
    assign restore_we = wr_acc && (paddr == `FE_RESTORE_OFS);

    // ==========================================
    // exception flags and events
    fpu_exc_flags #(.N(NF)) u_flags (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .set_flags(exc.valid ? exc.flags : '0),
        .clr(flag_clr || flag_init),
        .restore(restore_we),
        .restore_flags(pwdata[NF-1:0]),
        .flags_reg(flags)
    );

    fpu_evt_irq #(.N(NEVT)) u_evt (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .evt(evt),
        .clr_we(wr_acc && (paddr == `FE_EVT_CLR_OFS)),
        .en_we(wr_acc && (paddr == `FE_EVT_EN_OFS)),
        .wdata(pwdata[NEVT-1:0]),
        .status_reg(evt_status),
        .enable_reg(evt_enable),
        .irq(irq)
    );

    // ==========================================
    // freeze and error output
    always_comb begin
        pending = |(flags & ~mask_reg);
        new_unmasked = exc.valid && (|(exc.flags & ~mask_reg));
        waits = instr.valid && (instr.is_fp || instr.is_wait) && !instr.no_wait;
        honor = native_reg || ignore_numeric_error_in_n;
        stall_req = waits && pending && honor;
        instr_ready = (state_reg != fpu_err_pkg::ST_FROZEN) && !stall_req;
        accept_fp = instr.valid && instr.is_fp && instr_ready;
        state_next = state_reg;
        entry_next = 1'b0;
        unique case (state_reg)
            fpu_err_pkg::ST_RUN: begin
                if (stall_req) begin
                    state_next = fpu_err_pkg::ST_FROZEN;
                end
            end
            fpu_err_pkg::ST_FROZEN: begin
                if (maskable_irq_in) begin
                    state_next = fpu_err_pkg::ST_HANDLER;
                    entry_next = 1'b1;
                end
            end
            fpu_err_pkg::ST_HANDLER: begin
                if (stall_req) begin
                    state_next = fpu_err_pkg::ST_FROZEN;
                end else if (interrupt_return) begin
                    state_next = fpu_err_pkg::ST_RUN;
                end
            end
            default: begin
                state_next = fpu_err_pkg::ST_RUN;
            end
        endcase
        // compat reporting only while native reporting is off
        err_out_next = !native_reg && ((err_out_reg && pending) ||
                       (new_unmasked && exc.at_detect) || stall_req);
        abort_next = new_unmasked;
        ip_next = accept_fp ? instr.ip : ip_reg;
        op_next = accept_fp ? instr.op : op_reg;
        evt = '0;
        evt[`FE_EVT_UNMASKED] = new_unmasked;
        evt[`FE_EVT_FROZEN] = stall_req && (state_reg != fpu_err_pkg::ST_FROZEN);
        evt[`FE_EVT_HANDLER] = entry_next;
    end

    // ==========================================
    // apb registers
    always_comb begin
        mask_next = mask_reg;
        native_next = native_reg;
        if (flag_init) begin
            mask_next = `FE_MASK_RST;
        end else if (wr_acc && (paddr == `FE_CTRL_OFS)) begin
            mask_next = pwdata[NF-1:0];
            native_next = pwdata[`FE_NATIVE_BIT];
        end
        prdata_next = prdata_reg;
        slverr_next = slverr_reg;
        if (psel && !penable) begin
            slverr_next = !addr_hit(paddr);
            prdata_next = '0;
            unique case (paddr)
                `FE_CTRL_OFS: begin
                    prdata_next[NF-1:0] = mask_reg;
                    prdata_next[`FE_NATIVE_BIT] = native_reg;
                end
                `FE_STATUS_OFS: begin
                    prdata_next[NF-1:0] = flags;
                    prdata_next[`FE_ST_PEND_BIT] = pending;
                    prdata_next[`FE_ST_STATE_LSB +: 2] = state_reg;
                end
                `FE_IPTR_OFS: prdata_next = ip_reg;
                `FE_OPTR_OFS: prdata_next = op_reg;
                `FE_EVT_OFS: prdata_next[NEVT-1:0] = evt_status;
                `FE_EVT_EN_OFS: prdata_next[NEVT-1:0] = evt_enable;
                default: prdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= fpu_err_pkg::ST_RUN;
            mask_reg <= `FE_MASK_RST;
            native_reg <= `FE_NATIVE_RST;
            err_out_reg <= 1'b0;
            abort_reg <= 1'b0;
            entry_reg <= 1'b0;
            ip_reg <= '0;
            op_reg <= '0;
            prdata_reg <= '0;
            slverr_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            mask_reg <= mask_next;
            native_reg <= native_next;
            err_out_reg <= err_out_next;
            abort_reg <= abort_next;
            entry_reg <= entry_next;
            ip_reg <= ip_next;
            op_reg <= op_next;
            prdata_reg <= prdata_next;
            slverr_reg <= slverr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = psel && penable;
    assign pslverr = psel && penable && slverr_reg;
    assign fp_error_out_n = !err_out_reg;
    assign exc_abort = abort_reg;
    assign handler_entry = entry_reg;

    // ==========================================
    // checks
    chk_frozen_holds: assert property (@(posedge ref_clk) disable iff (rst)
        state_reg == fpu_err_pkg::ST_FROZEN && !maskable_irq_in
        |=> state_reg == fpu_err_pkg::ST_FROZEN)
        else $error("freeze left without an interrupt");
    chk_frozen_blocks: assert property (@(posedge ref_clk) disable iff (rst)
        state_reg == fpu_err_pkg::ST_FROZEN |-> !instr_ready)
        else $error("instruction accepted while frozen");
    chk_ignore_runs: assert property (@(posedge ref_clk) disable iff (rst)
        state_reg != fpu_err_pkg::ST_FROZEN && !native_reg && !ignore_numeric_error_in_n
        |-> instr_ready)
        else $error("stalled although error is ignored");
    chk_stall_pending: assert property (@(posedge ref_clk) disable iff (rst)
        instr.valid && instr.is_fp && !instr.no_wait && pending && ignore_numeric_error_in_n
        |-> !instr_ready)
        else $error("fp instruction passed a pending exception");
    chk_error_drops: assert property (@(posedge ref_clk) disable iff (rst)
        ce && !pending && !exc.valid && !stall_req |=> fp_error_out_n)
        else $error("error output held after flags cleared");
    chk_masked_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        ce && fp_error_out_n && !pending && !new_unmasked && !stall_req
        |=> fp_error_out_n)
        else $error("masked exception drove error output");
    chk_error_on_stall: assert property (@(posedge ref_clk) disable iff (rst)
        ce && stall_req && !native_reg |=> !fp_error_out_n [*1])
        else $error("no error output on freeze");
    chk_ptr_update: assert property (@(posedge ref_clk) disable iff (rst)
        ce && accept_fp |=> ip_reg == $past(instr.ip) && op_reg == $past(instr.op))
        else $error("pointers not taken at numeric start");
    chk_handler_entry: assert property (@(posedge ref_clk) disable iff (rst)
        ce && state_reg == fpu_err_pkg::ST_FROZEN && maskable_irq_in
        |=> handler_entry && state_reg == fpu_err_pkg::ST_HANDLER)
        else $error("handler not entered on interrupt");

    // ==========================================
    // further checks
    chk_abort_on_unmasked: assert property (@(posedge ref_clk) disable iff (rst)
        ce && new_unmasked
        |=> exc_abort)
        else $error("no abort after unmasked exception");
    chk_masked_no_abort: assert property (@(posedge ref_clk) disable iff (rst)
        ce && exc.valid && ((exc.flags & ~mask_reg) == 6'h00)
        |=> !exc_abort)
        else $error("masked exception aborted the instruction");
    chk_detect_error: assert property (@(posedge ref_clk) disable iff (rst)
        ce && new_unmasked && exc.at_detect && !native_reg
        |=> !fp_error_out_n)
        else $error("no error output at detection");
    chk_native_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        ce && native_reg
        |=> fp_error_out_n)
        else $error("error output driven in native mode");
    chk_handler_refreeze: assert property (@(posedge ref_clk) disable iff (rst)
        ce && state_reg == fpu_err_pkg::ST_HANDLER && stall_req
        |=> state_reg == fpu_err_pkg::ST_FROZEN)
        else $error("handler stall did not refreeze");
    chk_ptr_hold: assert property (@(posedge ref_clk) disable iff (rst)
        ce && !accept_fp
        |=> ip_reg == $past(ip_reg) && op_reg == $past(op_reg))
        else $error("pointers changed without numeric start");
    chk_ignore_no_freeze: assert property (@(posedge ref_clk) disable iff (rst)
        ce && state_reg == fpu_err_pkg::ST_RUN && !native_reg && !ignore_numeric_error_in_n
        |=> state_reg == fpu_err_pkg::ST_RUN)
        else $error("froze although error is ignored");
    chk_freeze_event: assert property (@(posedge ref_clk) disable iff (rst)
        ce && stall_req && state_reg == fpu_err_pkg::ST_RUN
        |=> evt_status[`FE_EVT_FROZEN])
        else $error("freeze entry not recorded");
endmodule

// ===== tb/fpu_glue_model.sv
// glue latch and interrupt controller model for the fp error pin
`timescale 1ns/100ps
module fpu_glue_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // error pin, port access, controller enable
    input wire logic fp_error_out_n,
    input wire logic port_clr,
    input wire logic irq_en,
    // request to the core
    output logic maskable_irq_in
);
    // ====
    // request latch
    logic err_d_reg;
    logic req_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            err_d_reg <= 1'b1;
            req_reg <= 1'b0;
        end else begin
            err_d_reg <= fp_error_out_n;
            if (port_clr) begin
                req_reg <= 1'b0;
            end else if (err_d_reg && !fp_error_out_n) begin
                req_reg <= 1'b1;
            end
        end
    end
    assign maskable_irq_in = req_reg && irq_en;
endmodule

// ===== tb/fpu_err_report_test.sv
// self-checking bench for the fp error reporting block
`timescale 1ns/100ps
`include "fpu_err_map.svh"
module fpu_err_report_test;
    // ====
    // signals
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    fpu_err_pkg::instr_t instr;
    fpu_err_pkg::exc_t exc;
    logic instr_ready, exc_abort, handler_entry, interrupt_return, irq, se;
    logic ignore_numeric_error_in_n, maskable_irq_in, fp_error_out_n, port_clr, irq_en;
    int errors, cmp_count, n;
    fpu_err_report DUT (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr(instr),
        .instr_ready(instr_ready), .exc(exc), .exc_abort(exc_abort),
        .handler_entry(handler_entry), .interrupt_return(interrupt_return),
        .ignore_numeric_error_in_n(ignore_numeric_error_in_n),
        .maskable_irq_in(maskable_irq_in), .fp_error_out_n(fp_error_out_n), .irq(irq));
    fpu_glue_model glue (.ref_clk(ref_clk), .rst(rst), .fp_error_out_n(fp_error_out_n),
        .port_clr(port_clr), .irq_en(irq_en), .maskable_irq_in(maskable_irq_in));
    // ====
    // tasks
    task automatic tk();
        @(posedge ref_clk);
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk_w({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        tk();
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        tk();
        penable <= 1'b1;
        do begin
            tk();
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_w(rd, exp);
    endtask
    task automatic give_verdict();
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ====
    // clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
    // ====
    // tests
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; instr = '0; exc = '0; interrupt_return = 1'b0;
        ignore_numeric_error_in_n = 1'b1; port_clr = 1'b0; irq_en = 1'b0;
        errors = 0; cmp_count = 0;
        repeat (2) tk();
        rst <= 1'b0;
        rchk(`FE_CTRL_OFS, 32'h3f);
        rchk(`FE_STATUS_OFS, 32'h0);
        rchk(8'h24, 32'h0);
        chk_b(se, 1'b1);
        // masked exception
        tk();
        exc <= '{1'b1, 1'b1, 6'h21};
        tk();
        exc <= '0;
        #10 chk_b(exc_abort, 1'b0);
        tk();
        #10 chk_b(fp_error_out_n, 1'b1);
        rchk(`FE_STATUS_OFS, 32'h21);
        wr(`FE_CMD_OFS, 32'h2);
        rchk(`FE_STATUS_OFS, 32'h0);
        // pointers
        tk();
        instr <= '{1'b1, 1'b1, 1'b0, 1'b0, 32'h1234_5678, 32'h0000_abc0};
        tk();
        instr <= '0;
        rchk(`FE_IPTR_OFS, 32'h1234_5678);
        rchk(`FE_OPTR_OFS, 32'h0000_abc0);
        // deferred error, freeze, handler
        wr(`FE_CTRL_OFS, 32'h0);
        wr(`FE_EVT_EN_OFS, 32'h7);
        tk();
        exc <= '{1'b1, 1'b0, 6'h01};
        tk();
        exc <= '0;
        instr <= '{1'b1, 1'b1, 1'b0, 1'b0, 32'h100, 32'h200};
        #10 chk_b(exc_abort, 1'b1);
        chk_b(instr_ready, 1'b0);
        chk_b(fp_error_out_n, 1'b1);
        repeat (5) tk();
        #10 chk_b(fp_error_out_n, 1'b0);
        chk_b(instr_ready, 1'b0);
        chk_b(handler_entry, 1'b0);
        chk_b(irq, 1'b1);
        tk();
        irq_en <= 1'b1;
        instr <= '0;
        n = 0;
        do begin
            tk();
            #10 n++;
        end while (handler_entry !== 1'b1 && n < 10);
        chk_b(handler_entry, 1'b1);
        rchk(`FE_STATUS_OFS, 32'h281);
        rchk(`FE_EVT_OFS, 32'h7);
        wr(`FE_EVT_EN_OFS, 32'h0);
        #10 chk_b(irq, 1'b0);
        wr(`FE_EVT_CLR_OFS, 32'h7);
        wr(`FE_EVT_EN_OFS, 32'h7);
        rchk(`FE_EVT_OFS, 32'h0);
        tk();
        port_clr <= 1'b1;
        tk();
        port_clr <= 1'b0;
        #10 chk_b(maskable_irq_in, 1'b0);
        chk_b(fp_error_out_n, 1'b0);
        wr(`FE_CMD_OFS, 32'h1);
        tk();
        #10 chk_b(fp_error_out_n, 1'b1);
        tk();
        interrupt_return <= 1'b1;
        tk();
        interrupt_return <= 1'b0;
        rchk(`FE_STATUS_OFS, 32'h0);
        // at-detect error, ignore input, no-wait, re-stall
        tk();
        exc <= '{1'b1, 1'b1, 6'h04};
        tk();
        exc <= '0;
        ignore_numeric_error_in_n <= 1'b0;
        instr <= '{1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 32'h0};
        #10 chk_b(instr_ready, 1'b1);
        tk();
        ignore_numeric_error_in_n <= 1'b1;
        instr <= '{1'b1, 1'b1, 1'b0, 1'b1, 32'h0, 32'h0};
        #10 chk_b(instr_ready, 1'b1);
        chk_b(fp_error_out_n, 1'b0);
        tk();
        instr <= '{1'b1, 1'b0, 1'b1, 1'b0, 32'h0, 32'h0};
        #10 chk_b(instr_ready, 1'b0);
        tk();
        instr <= '0;
        // native reporting: stall despite ignore, error output quiet
        wr(`FE_CTRL_OFS, 32'h100);
        tk();
        exc <= '{1'b1, 1'b1, 6'h01};
        ignore_numeric_error_in_n <= 1'b0;
        tk();
        exc <= '0;
        instr <= '{1'b1, 1'b1, 1'b0, 1'b0, 32'h0, 32'h0};
        #10 chk_b(instr_ready, 1'b0);
        chk_b(fp_error_out_n, 1'b1);
        tk();
        instr <= '0;
        ignore_numeric_error_in_n <= 1'b1;
        wr(`FE_RESTORE_OFS, 32'h0);
        rchk(`FE_STATUS_OFS, 32'h200);
        give_verdict();
    end
endmodule
